// ==== core/rlt_timer.sv ====
// 16-bit reload timer with split 8-bit mode and external clock capture
// assumes an AXI4-Lite master on aclk and an asynchronous ext_osc pin
//
// Operation
// - two count bytes, 16-bit or split 8-bit
// - system clock, its /12 or synchronised ext/8
// - 16-bit rollover reloads both bytes, sets high flag
// - 16-bit overflow interrupts when timer irq enabled
// - low byte rollover interrupts with low enable
// - split: each byte reloads from own reload
// - split: run gates high byte only
// - per-byte clock select with external select
// - split: byte overflows set their own flags
// - split: high always, low with low enable
// - hardware never clears flags; software must
// - capture copies count to reload, sets flag
// - capture on falling edge of ext/8
// - capture mode: low byte counts system clock or its /12
// - system clock select with capture: every cycle
// - control register at 0xC8, zero reset

`timescale 1ns/1ps
`default_nettype none

module rlt_timer
    import rlt_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              ext_osc,
    output logic                   irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == ADDR_CLK_CTRL) || (a == ADDR_IRQ_EN)
                 || (a == ADDR_CTRL)     || (a == ADDR_RL_LO)
                 || (a == ADDR_RL_HI)    || (a == ADDR_CNT_LO)
                 || (a == ADDR_CNT_HI)   || (a == ADDR_EVT_STAT)
                 || (a == ADDR_EVT_MASK);
    endfunction

    // count enable of one byte from its select bits
    function automatic logic pick_tick(input logic sys_sel, input logic x_sel,
                                       input logic t12, input logic tx);
        pick_tick = sys_sel ? 1'b1 : (x_sel ? tx : t12);
    endfunction

    rlt_ctrl_t         ctrl_q;
    logic [7:0]        clk_ctrl_q;
    logic              irq_en_q;
    logic [7:0]        rl_lo_q;
    logic [7:0]        rl_hi_q;
    logic [7:0]        cnt_lo_q;
    logic [7:0]        cnt_hi_q;
    logic [2:0]        evt_q;
    logic [2:0]        mask_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic              w_lane_q;
    logic              sys12_tick;
    logic              ext_tick;
    logic              cap_tick;

    // ------------------------------------------------------------
    // clock enables
    // ------------------------------------------------------------
    rlt_clk_div u_div (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ext_osc    (ext_osc),
        .sys12_tick (sys12_tick),
        .ext_tick   (ext_tick),
        .cap_tick   (cap_tick)
    );

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic wr_en;
    logic wr_go;

    assign wr_en = aw_got_q & w_got_q & ~bvalid;
    assign wr_go = wr_en & w_lane_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_lane_q  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end
        else
        begin
            // address and data are taken independently, in either order
            if (awvalid && awready)
            begin
                awready   <= 1'b0;
                aw_got_q  <= 1'b1;
                aw_addr_q <= awaddr;
            end
            else if (!aw_got_q && !bvalid)
                awready <= 1'b1;
            if (wvalid && wready)
            begin
                wready   <= 1'b0;
                w_got_q  <= 1'b1;
                w_data_q <= wdata;
                w_lane_q <= wstrb[0];
            end
            else if (!w_got_q && !bvalid)
                wready <= 1'b1;
            if (wr_en)
            begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
                bvalid <= 1'b0;
        end
    end

    // per-register write strobes, low byte lane only
    logic we_clk;
    logic we_ien;
    logic we_ctrl;
    logic we_rl_lo;
    logic we_rl_hi;
    logic we_cnt_lo;
    logic we_cnt_hi;
    logic we_evt;
    logic we_mask;

    assign we_clk    = wr_go & (aw_addr_q == ADDR_CLK_CTRL);
    assign we_ien    = wr_go & (aw_addr_q == ADDR_IRQ_EN);
    assign we_ctrl   = wr_go & (aw_addr_q == ADDR_CTRL);
    assign we_rl_lo  = wr_go & (aw_addr_q == ADDR_RL_LO);
    assign we_rl_hi  = wr_go & (aw_addr_q == ADDR_RL_HI);
    assign we_cnt_lo = wr_go & (aw_addr_q == ADDR_CNT_LO);
    assign we_cnt_hi = wr_go & (aw_addr_q == ADDR_CNT_HI);
    assign we_evt    = wr_go & (aw_addr_q == ADDR_EVT_STAT);
    assign we_mask   = wr_go & (aw_addr_q == ADDR_EVT_MASK);

    // ------------------------------------------------------------
    // count engine
    // ------------------------------------------------------------
    logic tick_lo;
    logic tick_hi;
    logic run16;
    logic lo_inc;
    logic hi_inc;
    logic lo_ovf;
    logic hi_ovf;
    logic cap_go;

    always_comb
    begin
        // capture mode only offers the low byte the system clock or its /12 tick
        tick_lo = pick_tick(clk_ctrl_q[CLK_LO_SYS_BIT],
                            ctrl_q.ext_clock_sel & ~ctrl_q.capture_enable,
                            sys12_tick, ext_tick);
        tick_hi = pick_tick(clk_ctrl_q[CLK_HI_SYS_BIT], ctrl_q.ext_clock_sel,
                            sys12_tick, ext_tick);
        run16   = ~ctrl_q.split_mode_sel & ctrl_q.run_control & tick_lo;
        lo_inc  = ctrl_q.split_mode_sel ? tick_lo : run16;
        hi_inc  = ctrl_q.split_mode_sel ? (ctrl_q.run_control & tick_hi)
                                        : (run16 & (cnt_lo_q == BYTE_ONES));
        lo_ovf  = lo_inc & (cnt_lo_q == BYTE_ONES);
        hi_ovf  = hi_inc & (cnt_hi_q == BYTE_ONES);
        cap_go  = ctrl_q.capture_enable & cap_tick;
    end

    // count bytes; a software write beats a count or reload
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_lo_q <= BYTE_RST;
            cnt_hi_q <= BYTE_RST;
        end
        else
        begin
            if (we_cnt_lo)
                cnt_lo_q <= w_data_q[7:0];
            else if (lo_ovf && (ctrl_q.split_mode_sel || hi_ovf))
                cnt_lo_q <= rl_lo_q;
            else if (lo_inc)
                cnt_lo_q <= cnt_lo_q + 8'h01;
            if (we_cnt_hi)
                cnt_hi_q <= w_data_q[7:0];
            else if (hi_ovf)
                cnt_hi_q <= rl_hi_q;
            else if (hi_inc)
                cnt_hi_q <= cnt_hi_q + 8'h01;
        end
    end

    // reload bytes, also the capture destination
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rl_lo_q <= BYTE_RST;
            rl_hi_q <= BYTE_RST;
        end
        else
        begin
            if (we_rl_lo)
                rl_lo_q <= w_data_q[7:0];
            else if (cap_go)
                rl_lo_q <= cnt_lo_q;
            if (we_rl_hi)
                rl_hi_q <= w_data_q[7:0];
            else if (cap_go)
                rl_hi_q <= cnt_hi_q;
        end
    end

    // ------------------------------------------------------------
    // control, clock select and flags
    // ------------------------------------------------------------
    // a flag set by hardware wins over a software clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q     <= CTRL_RST;
            clk_ctrl_q <= BYTE_RST;
            irq_en_q   <= 1'b0;
        end
        else
        begin
            if (we_ctrl)
            begin
                ctrl_q      <= rlt_ctrl_t'(w_data_q[7:0]);
                ctrl_q.rsvd <= 1'b0;
            end
            if (hi_ovf || cap_go)
                ctrl_q.high_overflow_flag <= 1'b1;
            if (lo_ovf)
                ctrl_q.low_overflow_flag <= 1'b1;
            if (we_clk)
                clk_ctrl_q <= w_data_q[7:0];
            if (we_ien)
                irq_en_q <= w_data_q[0];
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------
    logic [2:0] evt_set;

    assign evt_set = {cap_go, lo_ovf, hi_ovf};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            evt_q  <= EVT_RST;
            mask_q <= EVT_RST;
            irq    <= 1'b0;
        end
        else
        begin
            // write one to clear; a new event still lands
            evt_q <= (evt_q & ~(we_evt ? w_data_q[2:0] : 3'h0)) | evt_set;
            if (we_mask)
                mask_q <= w_data_q[2:0];
            // low flag only counts with low enable set
            irq <= (irq_en_q & (ctrl_q.high_overflow_flag
                   | (ctrl_q.low_irq_enable & ctrl_q.low_overflow_flag)))
                   | |(evt_q & mask_q);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb
    begin
        unique case (araddr)
            ADDR_CLK_CTRL: rd_byte = clk_ctrl_q;
            ADDR_IRQ_EN:   rd_byte = {7'h00, irq_en_q};
            ADDR_CTRL:     rd_byte = ctrl_q;
            ADDR_RL_LO:    rd_byte = rl_lo_q;
            ADDR_RL_HI:    rd_byte = rl_hi_q;
            ADDR_CNT_LO:   rd_byte = cnt_lo_q;
            ADDR_CNT_HI:   rd_byte = cnt_hi_q;
            ADDR_EVT_STAT: rd_byte = {5'h00, evt_q};
            ADDR_EVT_MASK: rd_byte = {5'h00, mask_q};
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_byte};
            rresp   <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid)
        begin
            if (rready)
                rvalid <= 1'b0;
        end
        else
            arready <= 1'b1;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RELOAD16: assert property (
        run16 && {cnt_hi_q, cnt_lo_q} == 16'hFFFF && !we_cnt_lo && !we_cnt_hi
        |=> {cnt_hi_q, cnt_lo_q} == $past({rl_hi_q, rl_lo_q}) && ctrl_q.high_overflow_flag)
        else $error("16-bit rollover did not reload and flag");

    AST_COUNT16: assert property (
        run16 && clk_ctrl_q[CLK_LO_SYS_BIT] && cnt_lo_q != BYTE_ONES
        && !we_cnt_lo && !we_cnt_hi
        |=> cnt_lo_q == $past(cnt_lo_q) + 8'h01 && cnt_hi_q == $past(cnt_hi_q))
        else $error("16-bit count did not step by one");

    AST_LO_FREE: assert property (
        ctrl_q.split_mode_sel && !ctrl_q.run_control && tick_lo
        && cnt_lo_q != BYTE_ONES && !we_cnt_lo
        |=> cnt_lo_q == $past(cnt_lo_q) + 8'h01)
        else $error("split low byte stopped with run clear");

    AST_HI_STOP: assert property (
        ctrl_q.split_mode_sel && !ctrl_q.run_control && !we_cnt_hi
        |=> $stable(cnt_hi_q))
        else $error("split high byte moved with run clear");

    AST_SPLIT_LO: assert property (
        ctrl_q.split_mode_sel && tick_lo && cnt_lo_q == BYTE_ONES && !we_cnt_lo
        |=> cnt_lo_q == $past(rl_lo_q) && ctrl_q.low_overflow_flag)
        else $error("split low overflow did not reload and flag");

    AST_IRQ16: assert property (
        irq_en_q && ctrl_q.high_overflow_flag |=> irq)
        else $error("high flag with irq enabled gave no interrupt");

    AST_LOW_IRQ: assert property (
        irq_en_q && ctrl_q.low_irq_enable && ctrl_q.low_overflow_flag |=> irq)
        else $error("low flag with low enable gave no interrupt");

    AST_NO_IRQ: assert property (
        !irq_en_q && (evt_q & mask_q) == 3'h0 |=> !irq)
        else $error("interrupt raised while disabled");

    AST_CAPTURE: assert property (
        cap_go && !we_rl_lo && !we_rl_hi
        |=> {rl_hi_q, rl_lo_q} == $past({cnt_hi_q, cnt_lo_q}) && ctrl_q.high_overflow_flag)
        else $error("capture did not copy count");

    AST_NO_AUTOCLR: assert property (
        ctrl_q.high_overflow_flag && !we_ctrl |=> ctrl_q.high_overflow_flag)
        else $error("high flag cleared without software");

    AST_SW_WINS: assert property (
        we_cnt_lo |=> cnt_lo_q == $past(w_data_q[7:0]))
        else $error("software write to count low lost");

    COV_WRAP16: cover property (run16 && {cnt_hi_q, cnt_lo_q} == 16'hFFFF);
    COV_SPLIT: cover property (ctrl_q.split_mode_sel && hi_ovf && lo_ovf);
    COV_CAP: cover property (cap_go ##[1:1000] cap_go);
    COV_IRQ: cover property ($rose(irq));

endmodule

`default_nettype wire

// ==== core/rlt_pkg.sv ====
// package for the 16-bit reload timer with capture
// assumes an AXI4-Lite host with 8-bit byte addresses and 32-bit data

package rlt_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  ADDR_CLK_CTRL = 8'hC0;
    localparam logic [7:0]  ADDR_IRQ_EN   = 8'hC4;
    localparam logic [7:0]  ADDR_CTRL     = 8'hC8;
    localparam logic [7:0]  ADDR_RL_LO    = 8'hCC;
    localparam logic [7:0]  ADDR_RL_HI    = 8'hD0;
    localparam logic [7:0]  ADDR_CNT_LO   = 8'hD4;
    localparam logic [7:0]  ADDR_CNT_HI   = 8'hD8;
    localparam logic [7:0]  ADDR_EVT_STAT = 8'hDC;
    localparam logic [7:0]  ADDR_EVT_MASK = 8'hE0;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          CLK_HI_SYS_BIT = 5;
    localparam int          CLK_LO_SYS_BIT = 4;
    localparam int          EVT_HI_BIT     = 0;
    localparam int          EVT_LO_BIT     = 1;
    localparam int          EVT_CAP_BIT    = 2;
    localparam logic [7:0]  BYTE_RST       = 8'h00;
    localparam logic [2:0]  EVT_RST        = 3'h0;
    localparam logic [7:0]  BYTE_ONES      = 8'hFF;

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    localparam int          SYS_DIV      = 12;
    localparam logic [3:0]  SYS_DIV_LAST = 4'(SYS_DIV - 1);
    localparam logic [2:0]  EXT_RISE_CNT = 3'h3;
    localparam logic [2:0]  EXT_FALL_CNT = 3'h7;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // timer control register layout, msb first
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_irq_enable;
        logic capture_enable;
        logic split_mode_sel;
        logic run_control;
        logic rsvd;
        logic ext_clock_sel;
    } rlt_ctrl_t;

    localparam rlt_ctrl_t CTRL_RST = 8'h00;

endpackage

// ==== core/rlt_clk_div.sv ====
// count clock enables: system clock / 12 and external oscillator / 8
// assumes ext_osc is asynchronous and much slower than aclk

`timescale 1ns/1ps
`default_nettype none

module rlt_clk_div
    import rlt_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ext_osc,
    output logic      sys12_tick,
    output logic      ext_tick,
    output logic      cap_tick
);

    logic [3:0] pre_q;
    logic [2:0] sync_q;
    logic [2:0] ediv_q;
    logic       ext_rise;

    // ------------------------------------------------------------
    // system clock prescaler
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pre_q      <= 4'h0;
            sys12_tick <= 1'b0;
        end
        else
        begin
            pre_q      <= (pre_q == SYS_DIV_LAST) ? 4'h0 : pre_q + 4'h1;
            sys12_tick <= (pre_q == SYS_DIV_LAST);
        end
    end

    // ------------------------------------------------------------
    // external clock synchroniser and divide by eight
    // ------------------------------------------------------------
    // sync_q[0] feeds only sync_q[1]; edge detect uses stages 1 and 2
    assign ext_rise = sync_q[1] & ~sync_q[2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_q   <= 3'h0;
            ediv_q   <= 3'h0;
            ext_tick <= 1'b0;
            cap_tick <= 1'b0;
        end
        else
        begin
            sync_q   <= {sync_q[1:0], ext_osc};
            ediv_q   <= ext_rise ? ediv_q + 3'h1 : ediv_q;
            // divided clock is ediv_q[2]: rises at 3->4, falls at 7->0
            ext_tick <= ext_rise & (ediv_q == EXT_RISE_CNT);
            cap_tick <= ext_rise & (ediv_q == EXT_FALL_CNT);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DIV12_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
        sys12_tick |-> ##12 sys12_tick)
        else $error("sys/12 tick period is not twelve cycles");

    AST_CAP_APART: assert property (@(posedge aclk) disable iff (!aresetn)
        cap_tick |-> !ext_tick)
        else $error("capture and count tick coincide");

endmodule

`default_nettype wire

// ==== dv/rlt_timer_tb.sv ====
// testbench for the reload timer: register traffic over AXI4-Lite
// assumes rlt_pkg and rlt_timer compiled first; ext_osc is made here
`timescale 1ns/1ps
`default_nettype none

module rlt_timer_tb
    import rlt_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_osc;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, v1;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          n_mismatch, n_tests, i;

    // ------------------------------------------------------------
    // clocks and design
    // ------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // 400 ns oscillator, slow enough for the two-flop synchroniser
    initial
    begin
        ext_osc = 1'b0;
        forever #200 ext_osc = ~ext_osc;
    end

    rlt_timer i_rlt_timer (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_osc(ext_osc), .irq(irq));

    // ------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= {24'h000000, v}; wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (awready === 1'b1 && !ad) begin ad = 1; awvalid <= 1'b0; end
            if (wready === 1'b1 && !wd) begin wd = 1; wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        cmp(d, exp);
    endtask

    // count readings carry a few cycles of bus latency, so a window
    task automatic rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        rd(a);
        cmp({31'h0, (d[7:0] >= lo && d[7:0] <= hi)}, 32'h1);
    endtask

    task automatic chk_irq(input logic e);
        repeat (2) @(posedge aclk);
        cmp({31'h0, irq}, {31'h0, e});
    endtask

    task automatic poll(input logic [7:0] a, input logic [7:0] m);
        for (int k = 0; k < 300; k++)
        begin
            rd(a);
            if ((d[7:0] & m) != 8'h00) break;
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    // watchdog: the sequence needs well under 20000 cycles
    initial
    begin
        #1000000;
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 9; i++) chk(8'hC0 + 8'(i * 4), 32'h0);
        rd(8'hF0);
        cmp({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'hF0, 8'h5A);
        cmp({30'h0, r}, {30'h0, RESP_SLVERR});
        // 16-bit rollover from 0xFFF0 on every system clock
        wr(8'hC0, 8'h10); wr(8'hC4, 8'h01); wr(8'hCC, 8'h34); wr(8'hD0, 8'h12);
        wr(8'hD4, 8'hF0); wr(8'hD8, 8'hFF); wr(8'hC8, 8'h06);
        poll(8'hC8, 8'h80);
        cmp(d, 32'hC4);
        chk_irq(1'b1);
        wr(8'hC8, 8'hC0);
        chk(8'hD8, 32'h12);
        repeat (20) @(posedge aclk);
        chk(8'hC8, 32'hC0);
        wr(8'hC8, 8'h00);
        chk_irq(1'b0);
        // low byte rollover only, with low interrupt enable
        wr(8'hD4, 8'hF0); wr(8'hD8, 8'h00); wr(8'hC8, 8'h24);
        poll(8'hC8, 8'h40);
        cmp(d, 32'h64);
        chk_irq(1'b1);
        wr(8'hC8, 8'h20);
        chk_irq(1'b0);
        // event status and mask
        wr(8'hC4, 8'h00);
        chk(8'hDC, 32'h03);
        chk_irq(1'b0);
        wr(8'hE0, 8'h01);
        chk_irq(1'b1);
        wr(8'hDC, 8'h01);
        chk(8'hDC, 32'h02);
        chk_irq(1'b0);
        wr(8'hDC, 8'h02); wr(8'hE0, 8'h00); wr(8'hC4, 8'h01);
        // split mode: with run clear only the low byte moves, with run set the high byte too
        wr(8'hCC, 8'h80); wr(8'hD4, 8'hF0); wr(8'hD8, 8'h55); wr(8'hC8, 8'h28);
        poll(8'hC8, 8'h40);
        rng(8'hD4, 8'h80, 8'hC0);
        chk(8'hD8, 32'h55);
        chk(8'hC8, 32'h68);
        chk_irq(1'b1);
        wr(8'hC0, 8'h30); wr(8'hD0, 8'hA0); wr(8'hD8, 8'hF8); wr(8'hC8, 8'h0C);
        poll(8'hC8, 8'h80);
        rng(8'hD8, 8'hA0, 8'hC0);
        chk_irq(1'b1);
        // divided clocks: /12 over 240 cycles, ext/8 (64 cycles a tick) over 1280
        wr(8'hC4, 8'h00); wr(8'hC0, 8'h00);
        for (i = 0; i < 2; i++)
        begin
            wr(8'hD4, 8'h00); wr(8'hD8, 8'h00); wr(8'hC8, 8'h04 | 8'(i));
            repeat (i ? 1280 : 240) @(posedge aclk);
            wr(8'hC8, 8'(i));
            rng(8'hD4, 8'd18, 8'd22);
        end
        // capture: 8 oscillator periods are 64 system clocks, or 5 to 6 ticks of /12;
        // the first capture of each setting may predate it, so it is skipped
        for (i = 0; i < 2; i++)
        begin
            wr(8'hC0, i ? 8'h00 : 8'h10); wr(8'hD4, 8'h00); wr(8'hD8, 8'h00);
            for (int k = 0; k < 3; k++)
            begin
                wr(8'hC8, 8'h14 | 8'(i));
                poll(8'hC8, 8'h80);
                v1[15:0] = v1[31:16];
                rd(8'hCC); v1[23:16] = d[7:0]; rd(8'hD0); v1[31:24] = d[7:0];
            end
            if (i == 0)
                cmp({16'h0, v1[31:16] - v1[15:0]}, 32'd64);
            else
                cmp({31'h0, (v1[31:16] - v1[15:0]) inside {16'd5, 16'd6}}, 32'h1);
        end
        print_verdict();
    end

endmodule

`default_nettype wire
